// >>> hw/dms_stretch_bus.sv
`timescale 1ns/100ps
`include "dms_defines.svh"
// Behaviour
// - Every machine cycle is four clocks; access lengths count these cycles.
// - Low address and data share port 0; high address drives port 2.
// - Program fetch takes one fixed machine cycle, never stretched.
// - Stretch sits in clock control bits 2..0 at 8Eh, any value 0..7.
// - A data move lasts stretch plus two machine cycles.
// - Reset loads stretch 1, giving three-cycle data moves.
// - Stretch 1..7 widens strobes and lengthens data move timing.
// - Strobe is 2 clocks at stretch 0, else 4 times stretch clocks.
// - Stretch applies to data moves only, program fetch unaffected.
// - Software may rewrite the stretch setting at any time.
module dms_stretch_bus (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic req_valid_in,
  input wire dms_pkg::dms_req_t req_in,
  output logic req_ready_out,
  output logic [1:0] mc_phase_out,
  output logic done_out,
  output logic [7:0] rdata_out,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  input wire logic [7:0] port0_addr_data_in,
  output logic [7:0] port0_addr_data_out,
  output logic port0_addr_data_oe_out,
  output logic [7:0] port2_high_addr_out,
  output logic ale_out,
  output logic psen_n_out,
  output logic rd_n_out,
  output logic wr_n_out
);
  import dms_pkg::*;

  function automatic logic [5:0] last_of(input dms_state_t st,
                                         input logic [2:0] s);
    logic [5:0] n;
    n = `DMS_MC_CLKS * `DMS_FETCH_MC - 6'd1;
    if (st != DMS_FETCH) begin
      n = `DMS_MC_CLKS * ({3'h0, s} + `DMS_EXTERNAL_DATA_MOVE_BASE_MC) - 6'd1;
    end
    return n;
  endfunction

  logic [1:0] phase_q, phase_d;
  logic [7:0] ccr_q, ccr_d;
  logic [7:0] sfr_rdata_q, sfr_rdata_d;
  dms_state_t st_q, st_d;
  logic [5:0] cnt_q, cnt_d;
  logic [2:0] str_q, str_d;
  logic [15:0] addr_q, addr_d;
  logic [7:0] wd_q, wd_d;
  logic ready_q, ready_d;
  logic take;
  logic [5:0] lst_q, lst_d;
  logic [5:0] sb, se;
  logic strobe, on;
  logic [7:0] p0_q, p0_d;
  logic p0_oe_q, p0_oe_d;
  logic [7:0] p2_q, p2_d;
  logic ale_q, ale_d;
  logic psen_n_q, psen_n_d;
  logic rd_n_q, rd_n_d;
  logic wr_n_q, wr_n_d;
  logic [`DMS_TAG_DEPTH-1:0] tag_q, tag_d;
  logic [`DMS_SYNC_DEPTH-1:0][7:0] sync_q, sync_d;
  logic [7:0] rdata_q, rdata_d;
  logic done_q, done_d;

  // Phase counter and register file
  always_comb begin
    phase_d = phase_q + 2'h1;
    ccr_d = ccr_q;
    if (sfr_wr_in && sfr_addr_in == `DMS_CCR_ADDR) begin
      ccr_d = sfr_wdata_in;
    end
    sfr_rdata_d = 8'h00;
    if (sfr_rd_in && sfr_addr_in == `DMS_CCR_ADDR) begin
      sfr_rdata_d = ccr_q;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_q <= 2'h0;
      ccr_q <= `DMS_CCR_RESET;
      sfr_rdata_q <= 8'h00;
    end else begin
      phase_q <= phase_d;
      ccr_q <= ccr_d;
      sfr_rdata_q <= sfr_rdata_d;
    end
  end

  // Access sequencer
  always_comb begin
    take = req_valid_in && ready_q && (req_in.kind != DMS_IDLE);
    st_d = st_q;
    cnt_d = cnt_q + 6'd1;
    str_d = str_q;
    addr_d = addr_q;
    wd_d = wd_q;
    if (st_q == DMS_IDLE || cnt_q == lst_q) begin
      cnt_d = 6'd0;
      st_d = DMS_IDLE;
      if (take) begin
        st_d = req_in.kind;
        addr_d = req_in.addr;
        wd_d = req_in.wdata;
        str_d = ccr_q[`DMS_STRETCH_MSB:`DMS_STRETCH_LSB];
      end
    end
    lst_d = last_of(st_d, str_d);
    ready_d = (phase_d == `DMS_MC_LAST_PHASE) &&
              (st_d == DMS_IDLE || cnt_d == lst_d);
  end

  // Strobe window and pin drive
  always_comb begin
    sb = `DMS_STB_START;
    se = `DMS_STB_START + `DMS_MC_CLKS * {3'h0, str_d} - 6'd1;
    if (str_d == 3'h0) begin
      sb = `DMS_STB0_START;
      se = `DMS_STB0_START + `DMS_STB0_CLKS - 6'd1;
    end
    if (st_d == DMS_FETCH) begin
      sb = `DMS_FETCH_STB_START;
      se = `DMS_FETCH_STB_START + `DMS_FETCH_STB_CLKS - 6'd1;
    end
    on = (st_d != DMS_IDLE);
    strobe = on && cnt_d >= sb && cnt_d <= se;
    ale_d = on && cnt_d == 6'd0;
    p0_d = (cnt_d <= `DMS_ADDR_LAST) ? addr_d[7:0] : wd_d;
    p0_oe_d = on && (cnt_d <= `DMS_ADDR_LAST || st_d == DMS_XWR);
    p2_d = on ? addr_d[15:8] : p2_q;
    psen_n_d = 1'b1;
    rd_n_d = 1'b1;
    wr_n_d = 1'b1;
    unique case (st_d)
      DMS_IDLE: begin
      end
      DMS_FETCH: begin
        psen_n_d = !strobe;
      end
      DMS_XRD: begin
        rd_n_d = !strobe;
      end
      DMS_XWR: begin
        wr_n_d = !strobe;
      end
    endcase
    tag_d = {tag_q[`DMS_TAG_DEPTH-2:0],
             strobe && st_d != DMS_XWR && cnt_d == se};
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= DMS_IDLE;
      cnt_q <= 6'd0;
      str_q <= 3'h0;
      addr_q <= 16'h0000;
      wd_q <= 8'h00;
      ready_q <= 1'b0;
      lst_q <= 6'd0;
      p0_q <= 8'h00;
      p0_oe_q <= 1'b0;
      p2_q <= 8'h00;
      ale_q <= 1'b0;
      psen_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      tag_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      str_q <= str_d;
      addr_q <= addr_d;
      wd_q <= wd_d;
      ready_q <= ready_d;
      lst_q <= lst_d;
      p0_q <= p0_d;
      p0_oe_q <= p0_oe_d;
      p2_q <= p2_d;
      ale_q <= ale_d;
      psen_n_q <= psen_n_d;
      rd_n_q <= rd_n_d;
      wr_n_q <= wr_n_d;
      tag_q <= tag_d;
    end
  end

  // Read capture behind the pin synchroniser
  always_comb begin
    sync_d = {sync_q[1], sync_q[0], port0_addr_data_in};
    rdata_d = rdata_q;
    if (tag_q[`DMS_TAG_DEPTH-1]) begin
      rdata_d = sync_q[2];
    end
    done_d = tag_q[`DMS_TAG_DEPTH-1] ||
             (st_q == DMS_XWR && cnt_q == lst_q);
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync_q <= '0;
      rdata_q <= 8'h00;
      done_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
      rdata_q <= rdata_d;
      done_q <= done_d;
    end
  end

  assign req_ready_out = ready_q;
  assign mc_phase_out = phase_q;
  assign done_out = done_q;
  assign rdata_out = rdata_q;
  assign sfr_rdata_out = sfr_rdata_q;
  assign port0_addr_data_out = p0_q;
  assign port0_addr_data_oe_out = p0_oe_q;
  assign port2_high_addr_out = p2_q;
  assign ale_out = ale_q;
  assign psen_n_out = psen_n_q;
  assign rd_n_out = rd_n_q;
  assign wr_n_out = wr_n_q;
endmodule

// >>> hw/dms_defines.svh
`ifndef DMS_DEFINES_SVH
`define DMS_DEFINES_SVH
// Clock control register
`define DMS_CCR_ADDR 8'h8e
`define DMS_CCR_RESET 8'h01
`define DMS_STRETCH_MSB 2
`define DMS_STRETCH_LSB 0
// Machine cycle framing
`define DMS_MC_CLKS 6'd4
`define DMS_MC_LAST_PHASE 2'h3
`define DMS_FETCH_MC 6'd1
`define DMS_EXTERNAL_DATA_MOVE_BASE_MC 6'd2
// Strobe placement, clock index within an access
`define DMS_ADDR_LAST 6'd1
`define DMS_FETCH_STB_START 6'd1
`define DMS_FETCH_STB_CLKS 6'd2
`define DMS_STB0_START 6'd5
`define DMS_STB0_CLKS 6'd2
`define DMS_STB_START 6'd4
// Read data pipeline depth behind the strobe
`define DMS_TAG_DEPTH 4
`define DMS_SYNC_DEPTH 3
`endif

// >>> hw/dms_pkg.sv
package dms_pkg;
  typedef enum logic [1:0] {
    DMS_IDLE = 2'b00,
    DMS_FETCH = 2'b01,
    DMS_XRD = 2'b10,
    DMS_XWR = 2'b11
  } dms_state_t;

  typedef struct packed {
    dms_state_t kind;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dms_req_t;
endpackage

// >>> testbench/dms_props.sv
`timescale 1ns/100ps
module dms_props (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic req_ready_out,
  input wire logic [1:0] mc_phase_out,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic port0_addr_data_oe_out,
  input wire logic ale_out,
  input wire logic psen_n_out,
  input wire logic rd_n_out,
  input wire logic wr_n_out
);
  logic [5:0] lo_q, lo_d;
  default clocking dcb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  always_comb lo_d = (!rd_n_out || !wr_n_out) ? lo_q + 6'h01 : 6'h00;
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
    if (!rst_n_in) lo_q <= 6'h00;
    else lo_q <= lo_d;
  sequence fetch_stb;
    !psen_n_out [*2] ##1 psen_n_out;
  endsequence
  a_phase_step: assert property ($past(rst_n_in) |->
    mc_phase_out == $past(mc_phase_out) + 2'h1)
    else $error("phase did not step");
  a_ready_phase: assert property (req_ready_out |-> mc_phase_out == 2'h3)
    else $error("ready outside last phase");
  a_ale_short: assert property ($rose(ale_out) |=> !ale_out)
    else $error("ale too long");
  a_fetch_fixed: assert property ($fell(psen_n_out) |-> fetch_stb)
    else $error("fetch strobe not two clocks");
  a_strobe_width: assert property ($rose(rd_n_out && wr_n_out) |->
    lo_q inside {6'h02, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h18, 6'h1c})
    else $error("strobe width wrong");
  a_rd_float: assert property (!rd_n_out |-> !port0_addr_data_oe_out)
    else $error("port driven during read");
  a_wr_drive: assert property (!wr_n_out |-> port0_addr_data_oe_out)
    else $error("port released during write");
  a_sfr_unmap: assert property (sfr_rd_in && sfr_addr_in != 8'h8e |=>
    sfr_rdata_out == 8'h00)
    else $error("unmapped read not zero");
endmodule

// >>> testbench/dms_mem_model.sv
`timescale 1ns/100ps
module dms_mem_model (
  input wire logic ref_clk_in,
  input wire logic [7:0] port0_addr_data_out,
  input wire logic ale_out,
  input wire logic psen_n_out,
  input wire logic rd_n_out,
  input wire logic wr_n_out,
  output logic [7:0] port0_addr_data_in
);
  logic [7:0] a, m [256];
  initial port0_addr_data_in = 8'h00;
  always @(posedge ref_clk_in) begin
    if (ale_out) a <= port0_addr_data_out;
    if (!wr_n_out) m[a] <= port0_addr_data_out;
    port0_addr_data_in <= !rd_n_out ? m[a] :
      !psen_n_out ? ~a : ~port0_addr_data_in;
  end
endmodule

// >>> testbench/dms_stretch_bus_test.sv
`timescale 1ns/100ps
module dms_stretch_bus_test;
  import dms_pkg::*;
  logic ref_clk_in = 1'h0, rst_n_in = 1'h0, req_valid_in = 1'h0, mid = 1'h0;
  logic sfr_wr_in = 1'h0, sfr_rd_in = 1'h0;
  logic [7:0] sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, cnt, lo;
  dms_req_t req_in = 26'h0;
  logic [7:0] port0_addr_data_in, port0_addr_data_out, port2_high_addr_out;
  logic [7:0] rdata_out, sfr_rdata_out;
  logic [1:0] mc_phase_out;
  logic req_ready_out, done_out, port0_addr_data_oe_out;
  logic ale_out, psen_n_out, rd_n_out, wr_n_out;
  int n_mismatch = 0, tests_run = 0;
  always #10 ref_clk_in = ~ref_clk_in;
  dms_stretch_bus i_dms_stretch_bus (.ref_clk_in, .rst_n_in, .req_valid_in,
    .req_in, .req_ready_out, .mc_phase_out, .done_out, .rdata_out, .sfr_wr_in,
    .sfr_rd_in, .sfr_addr_in, .sfr_wdata_in, .sfr_rdata_out,
    .port0_addr_data_in, .port0_addr_data_out, .port0_addr_data_oe_out,
    .port2_high_addr_out, .ale_out, .psen_n_out, .rd_n_out, .wr_n_out);
  dms_mem_model i_dms_mem_model (.ref_clk_in, .port0_addr_data_out, .ale_out,
    .psen_n_out, .rd_n_out, .wr_n_out, .port0_addr_data_in);
  task chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_in);
    {sfr_wr_in, sfr_rd_in, sfr_addr_in, sfr_wdata_in} = {w, !w, a, d};
    @(negedge ref_clk_in);
    {sfr_wr_in, sfr_rd_in} = 2'h0;
  endtask
  task acc(input dms_state_t k, input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk_in);
    req_valid_in = 1'h1;
    req_in = {k, a, d};
    while (req_ready_out !== 1'h1) @(negedge ref_clk_in);
    @(negedge ref_clk_in);
    {req_valid_in, cnt, lo} = 17'h0;
    while (done_out !== 1'h1 && cnt < 8'h63) begin
      lo += 8'(rd_n_out === 1'h0 || wr_n_out === 1'h0 || psen_n_out === 1'h0);
      if (mid) {sfr_wr_in, sfr_addr_in, sfr_wdata_in} = {cnt == 8'h0, 16'h8e00};
      cnt++;
      @(negedge ref_clk_in);
    end
  endtask
  task test_done;
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge ref_clk_in);
    rst_n_in = 1'h1;
    sfr(1'h0, 8'h8e, 8'h00);
    chk(sfr_rdata_out, 8'h01);
    sfr(1'h0, 8'h8d, 8'h00);
    chk(sfr_rdata_out, 8'h00);
    acc(DMS_XWR, 16'h0010, 8'h77);
    chk(cnt, 8'h0c);
    for (int s = 0; s < 8; s++) begin
      sfr(1'h1, 8'h8e, {5'h15, s[2:0]});
      sfr(1'h0, 8'h8e, 8'h00);
      chk(sfr_rdata_out, {5'h15, s[2:0]});
      acc(DMS_XWR, {8'h40 + s[7:0], 8'h20 + s[7:0]}, 8'ha0 + s[7:0]);
      chk(cnt, 8'(4 * s + 8));
      chk(lo, s ? 8'(4 * s) : 8'h02);
      mid = (s == 2);
      acc(DMS_XRD, {8'h40 + s[7:0], 8'h20 + s[7:0]}, 8'h00);
      mid = 1'h0;
      chk(cnt, s ? 8'(4 * s + 7) : 8'h0a);
      chk(lo, s ? 8'(4 * s) : 8'h02);
      chk(rdata_out, 8'ha0 + s[7:0]);
      chk(port2_high_addr_out, 8'h40 + s[7:0]);
      acc(DMS_FETCH, 16'h5ac3, 8'h00);
      chk(cnt, 8'h06);
      chk(lo, 8'h02);
      chk(rdata_out, 8'h3c);
      $display("stretch %0d test done", s);
    end
    test_done;
  end
  initial begin
    #200000;
    n_mismatch++;
    test_done;
  end
endmodule
bind dms_stretch_bus dms_props i_dms_props (.ref_clk_in, .rst_n_in,
  .req_ready_out, .mc_phase_out, .sfr_rd_in, .sfr_addr_in, .sfr_rdata_out,
  .port0_addr_data_oe_out, .ale_out, .psen_n_out, .rd_n_out, .wr_n_out);
